/* File: inc/wrs_pkg.sv */
package wrs_pkg;
   // receive status word 0 bit positions
   localparam int B_OWN   = 31;
   localparam int B_WRAP  = 30;
   localparam int B_FIRST = 29;
   localparam int B_LAST  = 28;
   localparam int B_DMAF  = 27;
   localparam int B_BEXH  = 26;
   localparam int B_SPRE  = 25;
   localparam int B_MCAST = 18;
   localparam int B_UCAST = 17;
   localparam int B_BCAST = 16;
   localparam int B_ERRS  = 15;
   localparam int B_PSAVE = 14;
   localparam int B_CRC   = 13;
   localparam int B_ICV   = 12;
   localparam int LEN_LSB = 0;
   localparam int LEN_W   = 12;
   // word 1 fields
   localparam int RSSI_LSB = 8;
   localparam int QUAL_LSB = 0;
   // group bit of the first destination octet
   localparam int DEST_GROUP_BIT = 40;
   // register map, byte addresses
   localparam logic [7:0] REG_CTRL      = 8'h00;
   localparam logic [7:0] REG_CLS       = 8'h04;
   localparam logic [7:0] REG_RING_BASE = 8'h08;
   localparam logic [7:0] REG_RING_IDX  = 8'h0C;
   localparam logic [7:0] REG_STA_LO    = 8'h10;
   localparam logic [7:0] REG_STA_HI    = 8'h14;
   localparam logic [7:0] REG_TMR_LO    = 8'h18;
   localparam logic [7:0] REG_TMR_HI    = 8'h1C;
   localparam logic [7:0] REG_DROPS     = 8'h20;
   // control register bits
   localparam int CTL_LOOP = 0;
   localparam int CTL_ACRC = 1;
   localparam int CTL_AICV = 2;
   localparam int CTL_MWI  = 4;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [7:0]  CLS_RST  = 8'h00;
   // ring geometry
   localparam int IDX_W   = 10;
   localparam int DESC_SH = 4;
   // bus commands and line sizes
   localparam logic [3:0] CMD_MR  = 4'h6;
   localparam logic [3:0] CMD_MW  = 4'h7;
   localparam logic [3:0] CMD_MRM = 4'hC;
   localparam logic [3:0] CMD_MRL = 4'hE;
   localparam logic [3:0] CMD_MWI = 4'hF;
   localparam logic [7:0] CLS_8   = 8'h08;
   localparam logic [7:0] CLS_16  = 8'h10;
   localparam logic [3:0] BE_ALL  = 4'hF;

   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WRITE = 2'b10} wrs_state_t;

   typedef struct packed {
      logic        first;
      logic        last;
      logic        dma_fail;
      logic        buf_exh;
      logic        short_pre;
      logic        power_save;
      logic        crc_err;
      logic        icv_err;
      logic        wrap;
      logic [47:0] dest;
      logic [11:0] length;
      logic [7:0]  rssi;
      logic [7:0]  quality;
   } wrs_seg_t;

   typedef struct packed {
      logic [31:0] w3;
      logic [31:0] w2;
      logic [31:0] w1;
      logic [31:0] w0;
   } wrs_desc_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [11:0] dwords;
   } wrs_xfer_t;

   typedef struct packed {
      logic [3:0]  cmd;
      logic [11:0] dwords;
      logic [3:0]  be;
   } wrs_cmd_t;
endpackage

/* File: design/wrs_cmd_pick.sv */
`timescale 1ns/1ps
module wrs_cmd_pick (
   input  wire logic              clk_in,      // bus clock
   input  wire logic              rst_n_in,    // sync reset, low
   input  wire logic              rd_req_in,   // read burst request
   input  wire wrs_pkg::wrs_xfer_t rd_xfer_in, // read address and length
   input  wire logic              tx_afull_in, // transmit fifo almost full
   input  wire logic              wr_req_in,   // write burst request
   input  wire wrs_pkg::wrs_xfer_t wr_xfer_in, // write address and length
   input  wire logic              wr_done_in,  // write burst finished
   input  wire logic [11:0]       rx_level_in, // receive fifo dwords
   input  wire logic [7:0]        cls_in,      // line size in dwords
   input  wire logic              mwi_en_in,   // invalidate enable
   output wrs_pkg::wrs_cmd_t      rd_cmd_out,  // chosen read command
   output wrs_pkg::wrs_cmd_t      wr_cmd_out,  // chosen write command
   output logic                   wr_line_stop_out // end at line end
);
   logic [7:0]  mask;
   logic        line_ok;
   logic [11:0] rd_off;
   logic [11:0] rd_bnd;
   logic [11:0] wr_off;
   logic        cond_now;
   logic        mwi_ok;
   logic        mwi_act_q;
   wrs_pkg::wrs_cmd_t rd_d;
   wrs_pkg::wrs_cmd_t wr_d;

   // line geometry; line size assumed a power of two
   assign mask    = cls_in - 8'h01;
   assign line_ok = (cls_in != wrs_pkg::CLS_RST);
   assign rd_off  = {4'h0, rd_xfer_in.addr[9:2] & mask};
   assign rd_bnd  = {4'h0, cls_in} - rd_off;
   assign wr_off  = {4'h0, wr_xfer_in.addr[9:2] & mask};
   assign cond_now = ((cls_in == wrs_pkg::CLS_8) || (cls_in == wrs_pkg::CLS_16))
                     && (rx_level_in >= {4'h0, cls_in}) && mwi_en_in;
   assign mwi_ok  = cond_now && (wr_off == 12'h000)
                    && (wr_xfer_in.dwords >= {4'h0, cls_in});

   // read command choice
   always_comb begin
      rd_d.be     = wrs_pkg::BE_ALL;
      rd_d.cmd    = wrs_pkg::CMD_MR;
      rd_d.dwords = rd_xfer_in.dwords;
      if (line_ok && rd_off != 12'h000) begin
         if (rd_xfer_in.dwords >= rd_bnd) begin
            rd_d.cmd    = wrs_pkg::CMD_MRL;
            rd_d.dwords = rd_bnd;
         end
      end else if (line_ok && rd_xfer_in.dwords >= {4'h0, cls_in}) begin
         rd_d.cmd = wrs_pkg::CMD_MRM;
         // short on room: stop on the first boundary
         rd_d.dwords = tx_afull_in ? {4'h0, cls_in}
                                   : (rd_xfer_in.dwords & ~{4'h0, mask});
      end
   end

   // write command choice
   always_comb begin
      wr_d.be     = wrs_pkg::BE_ALL;
      wr_d.cmd    = mwi_ok ? wrs_pkg::CMD_MWI : wrs_pkg::CMD_MW;
      wr_d.dwords = mwi_ok ? (wr_xfer_in.dwords & ~{4'h0, mask}) : wr_xfer_in.dwords;
   end

   // latch commands on request
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_cmd_out <= '0;
         wr_cmd_out <= '0;
      end else begin
         if (rd_req_in) begin
            rd_cmd_out <= rd_d;
         end
         if (wr_req_in) begin
            wr_cmd_out <= wr_d;
         end
      end
   end

   // track an invalidate burst in flight
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         mwi_act_q <= 1'b0;
      end else if (wr_req_in) begin
         mwi_act_q <= mwi_ok;
      end else if (wr_done_in) begin
         mwi_act_q <= 1'b0;
      end
   end

   // qualifier lost mid burst: finish the current line only
   assign wr_line_stop_out = mwi_act_q && !cond_now;

   a_mwi_chosen: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_req_in && mwi_ok |=> wr_cmd_out.cmd == wrs_pkg::CMD_MWI)
      else $error("invalidate not chosen when qualified");
   a_mw_fallback: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_req_in && !mwi_ok |=> wr_cmd_out.cmd == wrs_pkg::CMD_MW)
      else $error("invalidate chosen when not qualified");
   a_mwi_be_all: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_cmd_out.cmd == wrs_pkg::CMD_MWI |-> wr_cmd_out.be == wrs_pkg::BE_ALL)
      else $error("byte enables not all active");
   a_rd_short: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      rd_req_in && line_ok && rd_off != 12'h000 && rd_xfer_in.dwords < rd_bnd
      |=> rd_cmd_out.cmd == wrs_pkg::CMD_MR)
      else $error("short read not plain read");
   a_line_stop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      wr_req_in && mwi_ok ##1 !cond_now && !wr_done_in |-> wr_line_stop_out)
      else $error("no line stop after qualifier lost");
endmodule // wrs_cmd_pick

/* File: design/wrs_rx_dma.sv */
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module wrs_rx_dma (
   input  wire logic              REF_CLK_IN,         // bus clock
   input  wire logic              RESETN_IN,          // sync reset, low
   input  wire logic              WB_CYC_IN,          // bus cycle
   input  wire logic              WB_STB_IN,          // bus strobe
   input  wire logic              WB_WE_IN,           // write enable
   input  wire logic [7:0]        WB_ADR_IN,          // byte address
   input  wire logic [3:0]        WB_SEL_IN,          // byte selects
   input  wire logic [31:0]       WB_DAT_IN,          // write data
   output logic [31:0]            WB_DAT_OUT,         // read data
   output logic                   WB_ACK_OUT,         // acknowledge
   input  wire logic              RX_SEG_VALID_IN,    // segment finished
   input  wire wrs_pkg::wrs_seg_t RX_SEG_IN,          // segment status
   output logic                   RX_SEG_READY_OUT,   // status taken
   output logic                   DESC_VALID_OUT,     // write-back pending
   output logic [31:0]            DESC_ADDR_OUT,      // descriptor address
   output wrs_pkg::wrs_desc_t     DESC_OUT,           // four status words
   input  wire logic              DESC_READY_IN,      // write-back done
   output logic                   SEG_DROP_OUT,       // segment discarded
   input  wire logic [7:0]        TX_BYTE_IN,         // transmit byte
   input  wire logic              TX_BYTE_VALID_IN,   // transmit byte valid
   input  wire logic [7:0]        PHY_BYTE_IN,        // radio receive byte
   input  wire logic              PHY_BYTE_VALID_IN,  // radio byte valid
   output logic [7:0]             RX_BYTE_OUT,        // byte to receive logic
   output logic                   RX_BYTE_VALID_OUT,  // receive byte valid
   output logic [7:0]             PHY_TX_BYTE_OUT,    // byte to radio
   output logic                   PHY_TX_VALID_OUT,   // radio byte valid
   input  wire logic              RD_REQ_IN,          // read burst request
   input  wire wrs_pkg::wrs_xfer_t RD_XFER_IN,        // read burst
   input  wire logic              TX_FIFO_AFULL_IN,   // transmit fifo nearly full
   output wrs_pkg::wrs_cmd_t      RD_CMD_OUT,         // read command
   input  wire logic              WR_REQ_IN,          // write burst request
   input  wire wrs_pkg::wrs_xfer_t WR_XFER_IN,        // write burst
   input  wire logic              WR_DONE_IN,         // write burst over
   input  wire logic [11:0]       RX_FIFO_LEVEL_IN,   // receive fifo dwords
   output wrs_pkg::wrs_cmd_t      WR_CMD_OUT,         // write command
   output logic                   WR_LINE_STOP_OUT    // end at line end
);
   wrs_pkg::wrs_state_t state_q;
   wrs_pkg::wrs_desc_t  desc_d;
   logic [31:0]         ctrl_q;
   logic [7:0]          cls_q;
   logic [31:0]         ring_base_q;
   logic [wrs_pkg::IDX_W-1:0] idx_q;
   logic [31:0]         sta_lo_q;
   logic [15:0]         sta_hi_q;
   logic [31:0]         drops_q;
   logic [63:0]         tmr_q;
   logic                ack_q;
   logic                wb_req;
   logic                wb_wr;
   logic [31:0]         rd_val;
   logic                is_bcast;
   logic                is_mcast;
   logic                is_ucast;
   logic                drop;
   logic                take;

   // classic bus slave: ack one cycle after the request
   assign wb_req = WB_CYC_IN && WB_STB_IN;
   assign wb_wr  = wb_req && WB_WE_IN && ack_q;
   assign WB_ACK_OUT = ack_q;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= wb_req && !ack_q;
      end
   end

   // merge selected bytes into a register
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = new_v[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // writes land on the edge the master sees ack
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         ctrl_q      <= wrs_pkg::CTRL_RST;
         cls_q       <= wrs_pkg::CLS_RST;
         ring_base_q <= '0;
         sta_lo_q    <= '0;
         sta_hi_q    <= '0;
      end else if (wb_wr) begin
         if (WB_ADR_IN == wrs_pkg::REG_CTRL) begin
            ctrl_q <= merge(ctrl_q, WB_DAT_IN, WB_SEL_IN);
         end else if (WB_ADR_IN == wrs_pkg::REG_CLS && WB_SEL_IN[0]) begin
            cls_q <= WB_DAT_IN[7:0];
         end else if (WB_ADR_IN == wrs_pkg::REG_RING_BASE) begin
            ring_base_q <= merge(ring_base_q, WB_DAT_IN, WB_SEL_IN);
         end else if (WB_ADR_IN == wrs_pkg::REG_STA_LO) begin
            sta_lo_q <= merge(sta_lo_q, WB_DAT_IN, WB_SEL_IN);
         end else if (WB_ADR_IN == wrs_pkg::REG_STA_HI) begin
            sta_hi_q <= 16'(merge({16'h0000, sta_hi_q}, WB_DAT_IN, WB_SEL_IN));
         end
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rd_val = '0;
      if (WB_ADR_IN == wrs_pkg::REG_CTRL) begin
         rd_val = ctrl_q;
      end else if (WB_ADR_IN == wrs_pkg::REG_CLS) begin
         rd_val = {24'h000000, cls_q};
      end else if (WB_ADR_IN == wrs_pkg::REG_RING_BASE) begin
         rd_val = ring_base_q;
      end else if (WB_ADR_IN == wrs_pkg::REG_RING_IDX) begin
         rd_val = 32'(idx_q);
      end else if (WB_ADR_IN == wrs_pkg::REG_STA_LO) begin
         rd_val = sta_lo_q;
      end else if (WB_ADR_IN == wrs_pkg::REG_STA_HI) begin
         rd_val = {16'h0000, sta_hi_q};
      end else if (WB_ADR_IN == wrs_pkg::REG_TMR_LO) begin
         rd_val = tmr_q[31:0];
      end else if (WB_ADR_IN == wrs_pkg::REG_TMR_HI) begin
         rd_val = tmr_q[63:32];
      end else if (WB_ADR_IN == wrs_pkg::REG_DROPS) begin
         rd_val = drops_q;
      end
   end

   // read data captured as ack rises, held while ack stands
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         WB_DAT_OUT <= '0;
      end else if (wb_req && !ack_q) begin
         WB_DAT_OUT <= rd_val;
      end
   end

   // free running synchronisation timer
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         tmr_q <= '0;
      end else begin
         tmr_q <= tmr_q + 64'h0000_0000_0000_0001;
      end
   end

   // address classes; broadcast masks the group bit
   assign is_bcast = &RX_SEG_IN.dest;
   assign is_mcast = RX_SEG_IN.dest[wrs_pkg::DEST_GROUP_BIT] && !is_bcast;
   assign is_ucast = RX_SEG_IN.dest == {sta_hi_q, sta_lo_q};
   // errored frames only pass when software accepts them
   assign drop = (RX_SEG_IN.crc_err && !ctrl_q[wrs_pkg::CTL_ACRC])
              || (RX_SEG_IN.icv_err && !ctrl_q[wrs_pkg::CTL_AICV]);
   assign RX_SEG_READY_OUT = (state_q == wrs_pkg::ST_IDLE);
   assign take = RX_SEG_VALID_IN && RX_SEG_READY_OUT;

   // status words; ownership stays clear in the image
   always_comb begin
      desc_d = '0;
      desc_d.w0[wrs_pkg::B_OWN]   = 1'b0;
      desc_d.w0[wrs_pkg::B_WRAP]  = RX_SEG_IN.wrap;
      desc_d.w0[wrs_pkg::B_FIRST] = RX_SEG_IN.first;
      desc_d.w0[wrs_pkg::B_LAST]  = RX_SEG_IN.last;
      desc_d.w0[wrs_pkg::B_DMAF]  = RX_SEG_IN.dma_fail;
      desc_d.w0[wrs_pkg::B_BEXH]  = RX_SEG_IN.buf_exh;
      desc_d.w0[wrs_pkg::B_SPRE]  = RX_SEG_IN.short_pre;
      desc_d.w0[wrs_pkg::B_MCAST] = is_mcast;
      desc_d.w0[wrs_pkg::B_UCAST] = is_ucast;
      desc_d.w0[wrs_pkg::B_BCAST] = is_bcast;
      desc_d.w0[wrs_pkg::B_PSAVE] = RX_SEG_IN.power_save;
      desc_d.w0[wrs_pkg::B_CRC]   = RX_SEG_IN.crc_err;
      desc_d.w0[wrs_pkg::B_ICV]   = RX_SEG_IN.icv_err;
      desc_d.w1[wrs_pkg::RSSI_LSB +: 8] = RX_SEG_IN.rssi;
      desc_d.w1[wrs_pkg::QUAL_LSB +: 8] = RX_SEG_IN.quality;
      if (RX_SEG_IN.last) begin
         desc_d.w0[wrs_pkg::B_ERRS] = RX_SEG_IN.crc_err || RX_SEG_IN.icv_err;
         desc_d.w0[wrs_pkg::LEN_LSB +: wrs_pkg::LEN_W] = RX_SEG_IN.length;
         desc_d.w2 = tmr_q[31:0];
         desc_d.w3 = tmr_q[63:32];
      end
   end

   // write-back sequencer
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         state_q <= wrs_pkg::ST_IDLE;
      end else begin
         case (state_q)
            wrs_pkg::ST_IDLE: begin
               if (take && !drop) begin
                  state_q <= wrs_pkg::ST_WRITE;
               end
            end
            wrs_pkg::ST_WRITE: begin
               if (DESC_READY_IN) begin
                  state_q <= wrs_pkg::ST_IDLE;
               end
            end
            default: begin
               state_q <= wrs_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // whole image goes out in one write, so the owner flip
   // never lands ahead of the status fields
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         DESC_OUT      <= '0;
         DESC_ADDR_OUT <= '0;
      end else if (take && !drop) begin
         DESC_OUT      <= desc_d;
         DESC_ADDR_OUT <= ring_base_q + (32'(idx_q) << wrs_pkg::DESC_SH);
      end
   end
   assign DESC_VALID_OUT = (state_q == wrs_pkg::ST_WRITE);

   // ring pointer advances once the entry is handed back
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         idx_q <= '0;
      end else if (DESC_VALID_OUT && DESC_READY_IN) begin
         if (DESC_OUT.w0[wrs_pkg::B_WRAP]) begin
            idx_q <= '0;
         end else begin
            idx_q <= idx_q + 1'b1;
         end
      end
   end

   // dropped segments keep their descriptor for the next frame
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         SEG_DROP_OUT <= 1'b0;
         drops_q      <= '0;
      end else begin
         SEG_DROP_OUT <= take && drop;
         if (take && drop) begin
            drops_q <= drops_q + 32'h0000_0001;
         end
      end
   end

   // loopback: transmit bytes go to receive, radio sees none
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         RX_BYTE_OUT       <= '0;
         RX_BYTE_VALID_OUT <= 1'b0;
         PHY_TX_BYTE_OUT   <= '0;
         PHY_TX_VALID_OUT  <= 1'b0;
      end else if (ctrl_q[wrs_pkg::CTL_LOOP]) begin
         RX_BYTE_OUT       <= TX_BYTE_IN;
         RX_BYTE_VALID_OUT <= TX_BYTE_VALID_IN;
         PHY_TX_VALID_OUT  <= 1'b0;
      end else begin
         RX_BYTE_OUT       <= PHY_BYTE_IN;
         RX_BYTE_VALID_OUT <= PHY_BYTE_VALID_IN;
         PHY_TX_BYTE_OUT   <= TX_BYTE_IN;
         PHY_TX_VALID_OUT  <= TX_BYTE_VALID_IN;
      end
   end

   // bus command selection
   wrs_cmd_pick u_pick (
      .clk_in           (REF_CLK_IN),
      .rst_n_in         (RESETN_IN),
      .rd_req_in        (RD_REQ_IN),
      .rd_xfer_in       (RD_XFER_IN),
      .tx_afull_in      (TX_FIFO_AFULL_IN),
      .wr_req_in        (WR_REQ_IN),
      .wr_xfer_in       (WR_XFER_IN),
      .wr_done_in       (WR_DONE_IN),
      .rx_level_in      (RX_FIFO_LEVEL_IN),
      .cls_in           (cls_q),
      .mwi_en_in        (ctrl_q[wrs_pkg::CTL_MWI]),
      .rd_cmd_out       (RD_CMD_OUT),
      .wr_cmd_out       (WR_CMD_OUT),
      .wr_line_stop_out (WR_LINE_STOP_OUT)
   );

   a_own_clear: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      take && !drop |=> DESC_VALID_OUT && !DESC_OUT.w0[wrs_pkg::B_OWN])
      else $error("descriptor not released to host");
   a_ring_wrap: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      DESC_VALID_OUT && DESC_READY_IN && DESC_OUT.w0[wrs_pkg::B_WRAP] |=> idx_q == '0)
      else $error("ring pointer did not wrap");
   a_bc_mc_excl: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      DESC_VALID_OUT |-> !(DESC_OUT.w0[wrs_pkg::B_BCAST] && DESC_OUT.w0[wrs_pkg::B_MCAST]))
      else $error("broadcast and multicast both set");
   a_errs_last: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      DESC_VALID_OUT && !DESC_OUT.w0[wrs_pkg::B_LAST] |-> !DESC_OUT.w0[wrs_pkg::B_ERRS])
      else $error("error summary outside last segment");
   a_len_snap: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      take && !drop && RX_SEG_IN.last
      |=> DESC_OUT.w0[11:0] == $past(RX_SEG_IN.length) && DESC_OUT.w2 == $past(tmr_q[31:0]))
      else $error("length or timer snapshot wrong");
   a_crc_drop: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      take && RX_SEG_IN.crc_err && !ctrl_q[wrs_pkg::CTL_ACRC] |=> SEG_DROP_OUT && !DESC_VALID_OUT)
      else $error("crc error delivered without accept");
   a_drop_count: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      take && drop |=> drops_q == $past(drops_q) + 32'h0000_0001)
      else $error("dropped segment not counted");
   a_wb_stable: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      DESC_VALID_OUT && !DESC_READY_IN |=> DESC_VALID_OUT && $stable(DESC_OUT))
      else $error("write-back image changed while pending");
   a_loop_path: assert property (@(posedge REF_CLK_IN) disable iff (!RESETN_IN)
      ctrl_q[wrs_pkg::CTL_LOOP] && TX_BYTE_VALID_IN
      |=> RX_BYTE_VALID_OUT && RX_BYTE_OUT == $past(TX_BYTE_IN) && !PHY_TX_VALID_OUT)
      else $error("loopback byte not passed to receive");
endmodule // wrs_rx_dma

/* File: testbench/wrs_mem_model.sv */
`timescale 1ns/1ps
module wrs_mem_model (
   input  wire logic       clk_in,   // bus clock
   input  wire logic       rst_n_in, // sync reset, low
   input  wire logic       valid_in, // write-back pending
   input  wire logic [3:0] delay_in, // wait cycles
   output logic            ready_out // image written
);
   logic [3:0] cnt_q;
   // one-cycle ready after a chosen wait; the whole image lands at once
   // ready also stands for the host re-arming the entry with size and buffer address
   always_ff @(posedge clk_in) begin
      cnt_q     <= (rst_n_in && valid_in && !ready_out) ? cnt_q + 4'h1 : 4'h0;
      ready_out <= rst_n_in && valid_in && !ready_out && (cnt_q >= delay_in);
   end
endmodule // wrs_mem_model

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic REF_CLK_IN, RESETN_IN, WB_CYC_IN, WB_STB_IN, WB_WE_IN, WB_ACK_OUT, RX_SEG_VALID_IN, RX_SEG_READY_OUT;
   logic DESC_VALID_OUT, DESC_READY_IN, SEG_DROP_OUT, TX_BYTE_VALID_IN, PHY_BYTE_VALID_IN, RX_BYTE_VALID_OUT;
   logic PHY_TX_VALID_OUT, RD_REQ_IN, TX_FIFO_AFULL_IN, WR_REQ_IN, WR_DONE_IN, WR_LINE_STOP_OUT;
   logic [7:0]  WB_ADR_IN, TX_BYTE_IN, PHY_BYTE_IN, RX_BYTE_OUT, PHY_TX_BYTE_OUT;
   logic [3:0]  WB_SEL_IN, mem_dly;
   logic [11:0] RX_FIFO_LEVEL_IN;
   logic [31:0] WB_DAT_IN, WB_DAT_OUT, DESC_ADDR_OUT, rd_q;
   wrs_pkg::wrs_seg_t  RX_SEG_IN;
   wrs_pkg::wrs_desc_t DESC_OUT;
   wrs_pkg::wrs_xfer_t RD_XFER_IN, WR_XFER_IN;
   wrs_pkg::wrs_cmd_t  RD_CMD_OUT, WR_CMD_OUT;
   int bad_count, cmp_count, cyc_n;
   wrs_rx_dma u_dut (.REF_CLK_IN, .RESETN_IN, .WB_CYC_IN, .WB_STB_IN, .WB_WE_IN, .WB_ADR_IN, .WB_SEL_IN,
      .WB_DAT_IN, .WB_DAT_OUT, .WB_ACK_OUT, .RX_SEG_VALID_IN, .RX_SEG_IN, .RX_SEG_READY_OUT, .DESC_VALID_OUT,
      .DESC_ADDR_OUT, .DESC_OUT, .DESC_READY_IN, .SEG_DROP_OUT, .TX_BYTE_IN, .TX_BYTE_VALID_IN, .PHY_BYTE_IN,
      .PHY_BYTE_VALID_IN, .RX_BYTE_OUT, .RX_BYTE_VALID_OUT, .PHY_TX_BYTE_OUT, .PHY_TX_VALID_OUT, .RD_REQ_IN,
      .RD_XFER_IN, .TX_FIFO_AFULL_IN, .RD_CMD_OUT, .WR_REQ_IN, .WR_XFER_IN, .WR_DONE_IN, .RX_FIFO_LEVEL_IN,
      .WR_CMD_OUT, .WR_LINE_STOP_OUT);
   wrs_mem_model u_mem (.clk_in(REF_CLK_IN), .rst_n_in(RESETN_IN), .valid_in(DESC_VALID_OUT),
      .delay_in(mem_dly), .ready_out(DESC_READY_IN));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, s, e);
      end
   endtask
   // classic cycle: hold until ack is sampled, then release for a cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      WB_CYC_IN <= 1'b1; WB_STB_IN <= 1'b1; WB_WE_IN <= we; WB_ADR_IN <= a; WB_DAT_IN <= d;
      do @(posedge REF_CLK_IN); while (WB_ACK_OUT !== 1'b1);
      rd_q = WB_DAT_OUT;
      WB_CYC_IN <= 1'b0; WB_STB_IN <= 1'b0;
      @(posedge REF_CLK_IN);
   endtask
   task automatic seg(input wrs_pkg::wrs_seg_t s, input logic [31:0] w0, input logic [31:0] a, input logic drop);
      RX_SEG_IN <= s; RX_SEG_VALID_IN <= 1'b1;
      do @(posedge REF_CLK_IN); while (RX_SEG_READY_OUT !== 1'b1);
      RX_SEG_VALID_IN <= 1'b0;
      @(posedge REF_CLK_IN);
      chk(SEG_DROP_OUT, drop);
      chk(DESC_VALID_OUT, !drop);
      if (!drop) begin
         chk(DESC_OUT.w0, w0);
         chk(DESC_ADDR_OUT, a);
         chk(DESC_OUT.w1, {16'h0000, s.rssi, s.quality});
         chk(DESC_OUT.w2 != 32'h0000_0000, s.last);
         chk(DESC_OUT.w3, 32'h0000_0000);
      end
      while (DESC_VALID_OUT !== 1'b0) @(posedge REF_CLK_IN);
   endtask
   task automatic cmd(input logic rd, input wrs_pkg::wrs_xfer_t x, input logic [3:0] c, input logic [11:0] dw);
      RD_REQ_IN <= rd; WR_REQ_IN <= !rd; RD_XFER_IN <= x; WR_XFER_IN <= x;
      @(posedge REF_CLK_IN);
      RD_REQ_IN <= 1'b0; WR_REQ_IN <= 1'b0;
      @(posedge REF_CLK_IN);
      if (rd) chk({RD_CMD_OUT.cmd, RD_CMD_OUT.dwords}, {c, dw});
      else chk({WR_CMD_OUT.cmd, WR_CMD_OUT.be}, {c, 4'hF});
   endtask
   task automatic t_desc;
      wb(1'b1, wrs_pkg::REG_RING_BASE, 32'h0000_1000);
      wb(1'b1, wrs_pkg::REG_CTRL, 32'h0000_0006);
      wb(1'b0, 8'h40, 32'h0000_0000);
      chk(rd_q, 32'h0000_0000);
      seg('{1, 0, 0, 0, 1, 1, 0, 0, 0, 48'hFFFF_FFFF_FFFF, 12'h05A, 8'h11, 8'h33}, 32'h2201_4000, 32'h0000_1000, 0);
      mem_dly <= 4'h0;
      wb(1'b1, wrs_pkg::REG_STA_HI, 32'h0000_0100);
      seg('{0, 1, 1, 1, 0, 0, 1, 0, 1, 48'h0100_0000_0000, 12'h03C, 8'h77, 8'h22}, 32'h5C06_A03C, 32'h0000_1010, 0);
      wb(1'b0, wrs_pkg::REG_RING_IDX, 32'h0000_0000);
      chk(rd_q, 32'h0000_0000);
      wb(1'b1, wrs_pkg::REG_CTRL, 32'h0000_0000);
      seg('{1, 1, 0, 0, 0, 0, 0, 1, 0, 48'h0, 12'h040, 8'h00, 8'h00}, 32'h0, 32'h0, 1);
      wb(1'b0, wrs_pkg::REG_DROPS, 32'h0000_0000);
      chk(rd_q, 32'h0000_0001);
   endtask
   task automatic t_cmds;
      wb(1'b1, wrs_pkg::REG_CLS, 32'h0000_0010);
      wb(1'b1, wrs_pkg::REG_CTRL, 32'h0000_0010);
      cmd(0, '{32'h0000_0040, 12'h010}, wrs_pkg::CMD_MWI, 12'h000);
      // fifo level drops under a line while the invalidate burst is open
      RX_FIFO_LEVEL_IN <= 12'h008;
      @(posedge REF_CLK_IN);
      chk(WR_LINE_STOP_OUT, 1'b1);
      WR_DONE_IN <= 1'b1;
      @(posedge REF_CLK_IN);
      WR_DONE_IN <= 1'b0;
      @(posedge REF_CLK_IN);
      chk(WR_LINE_STOP_OUT, 1'b0);
      RX_FIFO_LEVEL_IN <= 12'h010;
      cmd(0, '{32'h0000_0044, 12'h010}, wrs_pkg::CMD_MW, 12'h000);
      cmd(1, '{32'h0000_0044, 12'h020}, wrs_pkg::CMD_MRL, 12'h00F);
      cmd(1, '{32'h0000_0044, 12'h002}, wrs_pkg::CMD_MR, 12'h002);
      cmd(1, '{32'h0000_0080, 12'h020}, wrs_pkg::CMD_MRM, 12'h020);
      TX_FIFO_AFULL_IN <= 1'b1;
      cmd(1, '{32'h0000_0080, 12'h020}, wrs_pkg::CMD_MRM, 12'h010);
   endtask
   // loopback: transmit byte shows on receive side, radio stays quiet
   task automatic t_loop;
      wb(1'b1, wrs_pkg::REG_CTRL, 32'h0000_0001);
      TX_BYTE_IN <= 8'hA5; TX_BYTE_VALID_IN <= 1'b1; PHY_BYTE_IN <= 8'h3C; PHY_BYTE_VALID_IN <= 1'b1;
      @(posedge REF_CLK_IN);
      TX_BYTE_VALID_IN <= 1'b0;
      @(posedge REF_CLK_IN);
      chk({RX_BYTE_VALID_OUT, RX_BYTE_OUT, PHY_TX_VALID_OUT}, {1'b1, 8'hA5, 1'b0});
      // normal mode: radio feeds receive, transmit goes to radio
      wb(1'b1, wrs_pkg::REG_CTRL, 32'h0000_0000);
      TX_BYTE_VALID_IN <= 1'b1;
      @(posedge REF_CLK_IN);
      {TX_BYTE_VALID_IN, PHY_BYTE_VALID_IN} <= 2'b00;
      @(posedge REF_CLK_IN);
      chk({RX_BYTE_VALID_OUT, RX_BYTE_OUT, PHY_TX_VALID_OUT, PHY_TX_BYTE_OUT}, {1'b1, 8'h3C, 1'b1, 8'hA5});
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      REF_CLK_IN = 1'b0;
      forever #5 REF_CLK_IN = ~REF_CLK_IN;
   end
   // hang guard, far above the fewer than a hundred cycles the run needs
   always @(posedge REF_CLK_IN) begin
      cyc_n++;
      if (cyc_n == 5000) begin
         bad_count++;
         print_verdict();
      end
   end
   initial begin
      {RESETN_IN, WB_CYC_IN, WB_STB_IN, WB_WE_IN, RX_SEG_VALID_IN, TX_BYTE_VALID_IN, PHY_BYTE_VALID_IN} = '0;
      {RD_REQ_IN, TX_FIFO_AFULL_IN, WR_REQ_IN, WR_DONE_IN, WB_ADR_IN, TX_BYTE_IN, PHY_BYTE_IN} = '0;
      {WB_DAT_IN, RX_SEG_IN, RD_XFER_IN, WR_XFER_IN} = '0;
      WB_SEL_IN = 4'hF; RX_FIFO_LEVEL_IN = 12'h010; mem_dly = 4'h3;
      repeat (10) @(posedge REF_CLK_IN);
      RESETN_IN <= 1'b1;
      t_desc();
      t_cmds();
      t_loop();
      print_verdict();
   end
endmodule // testbench
